//--- tcsp_timer.sv
// Purpose: 8-bit timer/counter with a prescaler shared with the watchdog.
// Assumes: All inputs synchronous to clk; watchdog counter lives elsewhere.
// Notes:   One instruction cycle is four clk cycles, phases Q1 to Q4.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "tcsp_consts.svh"

module tcsp_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire tcsp_pkg::tcsp_av_req_s av_req,
    output logic [31:0] av_readdata,
    output logic av_waitrequest,
    // External count pin
    input wire logic ext_count_pin_in,
    output logic ext_count_pin_out,
    output logic ext_count_pin_oe_n,
    // Port latch level for the pin when used as plain output
    input wire logic gpio_level,
    // Raw comparator result
    input wire logic cmp_level,
    // Watchdog side
    input wire logic wdt_tick,
    output logic wdt_post_tick
);

    // ==========================================================
    // Reset release
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction : hit

    logic wait_q;
    logic req_any;
    logic acc;
    logic wr_timer;
    logic wr_cmp;
    logic wr_setup;
    logic wr_pindir;
    logic wr_wdtclr;

    assign req_any = av_req.read | av_req.write;
    assign acc = req_any & ~wait_q;
    assign wr_timer = acc & av_req.write & hit(av_req.address, `TCSP_IDX_TIMER); // see R16
    assign wr_cmp = acc & av_req.write & hit(av_req.address, `TCSP_IDX_CMPCTL);
    assign wr_setup = acc & av_req.write & hit(av_req.address, `TCSP_IDX_SETUP);
    assign wr_pindir = acc & av_req.write & hit(av_req.address, `TCSP_IDX_PINDIR);
    assign wr_wdtclr = acc & av_req.write & hit(av_req.address, `TCSP_IDX_WDTCLR);

    // ==========================================================
    // Software registers
    logic [7:0] timer_q;
    logic [7:0] timer_d;
    tcsp_pkg::tcsp_setup_s setup_q;
    tcsp_pkg::tcsp_cmpctl_s cmpctl_q;
    logic [3:0] pin_direction_q;

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            setup_q <= `TCSP_RST_SETUP;
            cmpctl_q <= `TCSP_RST_CMPCTL;
            pin_direction_q <= `TCSP_RST_PINDIR;
        end else begin
            if (wr_setup) begin
                setup_q <= av_req.writedata[7:0];
            end
            if (wr_cmp) begin
                cmpctl_q <= {1'b1, av_req.writedata[6:0]};
            end
            if (wr_pindir) begin
                pin_direction_q <= av_req.writedata[3:0];
            end
        end
    end

    // ==========================================================
    // Phase sequencer
    tcsp_pkg::tcsp_phase_e phase_q;
    tcsp_pkg::tcsp_phase_e phase_d;
    logic instr_tick;

    always_comb begin
        unique case (phase_q)
            tcsp_pkg::PH_Q1: phase_d = tcsp_pkg::PH_Q2;
            tcsp_pkg::PH_Q2: phase_d = tcsp_pkg::PH_Q3;
            tcsp_pkg::PH_Q3: phase_d = tcsp_pkg::PH_Q4;
            tcsp_pkg::PH_Q4: phase_d = tcsp_pkg::PH_Q1;
        endcase
    end

    assign instr_tick = (phase_q == tcsp_pkg::PH_Q4);

    // ==========================================================
    // Source selection
    logic ext_mode;
    logic pin_mode;
    logic loop_mode;
    logic cmp_res;
    logic src_raw;
    logic src_pol;
    logic src_prev_q;
    logic src_edge;
    logic psa_timer;

    assign cmp_res = cmp_level ^ ~cmpctl_q.polarity;
    assign ext_mode = setup_q.count_source_sel;
    assign pin_mode = ext_mode & cmpctl_q.comparator_clock_select & cmpctl_q.comparator_output_disable; // see R3
    assign loop_mode = ext_mode & cmpctl_q.comparator_clock_select & ~cmpctl_q.comparator_output_disable; // see R6
    // Pin path serves both pin and loop-back counting; else internal comparator
    assign src_raw = cmpctl_q.comparator_clock_select ? ext_count_pin_in : cmp_res; // see R5
    assign src_pol = src_raw ^ setup_q.edge_select; // see R4
    assign src_edge = src_pol & ~src_prev_q;
    assign psa_timer = ~setup_q.prescaler_assign; // see R7

    // ==========================================================
    // Shared prescaler
    // Modelled as a synchronous counter, so it never shows ripple glitches
    logic [7:0] ps_q;
    logic ps_in;
    logic ps_clr;
    logic ps_bit;
    logic ps_bit_prev_q;
    logic pre_out;

    assign ps_in = psa_timer ? (ext_mode ? src_edge : instr_tick) : wdt_tick; // see R7
    assign ps_clr = psa_timer ? wr_timer : wr_wdtclr; // see R17
    assign ps_bit = ps_q[setup_q.ratio_field]; // see R9, R19, R20
    assign pre_out = psa_timer ? ps_bit : src_pol;

    // ==========================================================
    // Phase-two and phase-four sampling
    logic samp2_q;
    logic samp4_q;
    logic sync_rise;

    assign sync_rise = instr_tick & samp2_q & ~samp4_q; // see R10, R12

    // ==========================================================
    // Timer count
    logic [1:0] inhibit_q;
    logic inc_src;
    logic inc_en;

    assign inc_src = (ext_mode | psa_timer) ? sync_rise : instr_tick; // see R1
    assign inc_en = inc_src & (inhibit_q == 2'h0); // see R2
    assign timer_d = wr_timer ? av_req.writedata[7:0] : (timer_q + {7'h0, inc_en}); // see R20

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            phase_q <= tcsp_pkg::PH_Q1;
            src_prev_q <= 1'b0;
            ps_q <= 8'h00; // see R18
            ps_bit_prev_q <= 1'b0;
            samp2_q <= 1'b0;
            samp4_q <= 1'b0;
            inhibit_q <= 2'h0;
            timer_q <= `TCSP_RST_TIMER;
        end else begin
            phase_q <= phase_d;
            src_prev_q <= src_pol;
            ps_q <= ps_clr ? 8'h00 : (ps_q + {7'h0, ps_in}); // see R17
            ps_bit_prev_q <= ps_bit;
            if (phase_q == tcsp_pkg::PH_Q2) begin
                samp2_q <= pre_out; // see R10
            end
            if (instr_tick) begin
                samp4_q <= samp2_q;
            end
            if (wr_timer) begin
                inhibit_q <= `TCSP_INHIBIT_CYC; // see R2
            end else if (instr_tick && inhibit_q != 2'h0) begin
                inhibit_q <= inhibit_q - 2'h1;
            end
            timer_q <= timer_d;
        end
    end

    // ==========================================================
    // Bus answer and pin outputs
    // Prescaler has no read path at all
    logic [7:0] rd_byte;
    logic pin_oe_n_d;
    logic pin_out_d;

    assign rd_byte = hit(av_req.address, `TCSP_IDX_TIMER) ? timer_q : // see R8
        hit(av_req.address, `TCSP_IDX_CMPCTL) ? {cmp_res, cmpctl_q[6:0]} : 8'h00;
    // Direction bit only counts while the timer does not own the pin
    assign pin_oe_n_d = ext_mode ? ~loop_mode : pin_direction_q[`TCSP_PIN_BIT]; // see R15, R6
    assign pin_out_d = loop_mode ? cmp_res : gpio_level; // see R6

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wait_q <= 1'b1;
            av_readdata <= 32'h0000_0000;
            ext_count_pin_oe_n <= 1'b1;
            ext_count_pin_out <= 1'b0;
            wdt_post_tick <= 1'b0;
        end else begin
            wait_q <= ~(req_any & wait_q);
            if (req_any && wait_q) begin
                av_readdata <= {24'h00_0000, rd_byte};
            end
            ext_count_pin_oe_n <= pin_oe_n_d;
            ext_count_pin_out <= pin_out_d;
            wdt_post_tick <= ~psa_timer & ps_bit & ~ps_bit_prev_q; // see R7
        end
    end

    assign av_waitrequest = wait_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_q);

    sequence timer_written_s;
        wr_timer;
    endsequence

    sequence timer_frozen_s;
        $stable(timer_q) [*4];
    endsequence

    // Load edge itself changes the count, so the freeze is checked from the edge after
    inhibit_hold_a: assert property (timer_written_s |=> ##1 timer_frozen_s) // see R2
        else $error("timer moved during write inhibit");

    internal_inc_a: assert property (!ext_mode && !psa_timer && instr_tick && inhibit_q == 2'h0 && !wr_timer
        |=> timer_q == $past(timer_q) + 8'h01) // see R1
        else $error("timer missed internal increment");

    sync_inc_a: assert property (ext_mode && sync_rise && inhibit_q == 2'h0 && !wr_timer
        |=> timer_q == $past(timer_q) + 8'h01) // see R12
        else $error("timer missed synchronised edge");

    ps_timer_clr_a: assert property (psa_timer && wr_timer |=> ps_q == 8'h00) // see R17
        else $error("timer write left prescaler set");

    ps_wdt_clr_a: assert property (!psa_timer && wr_wdtclr |=> ps_q == 8'h00) // see R17
        else $error("watchdog clear left prescaler set");

    ps_owner_a: assert property (!psa_timer && !wr_wdtclr && !wdt_tick |=> $stable(ps_q)) // see R7
        else $error("prescaler counted for timer while owned by watchdog");

    pin_override_a: assert property (ext_mode && !loop_mode ##1 ext_mode && !loop_mode
        |-> ext_count_pin_oe_n) // see R15
        else $error("pin driven while timer owns it as input");

    loop_drive_a: assert property (loop_mode |=> !ext_count_pin_oe_n && ext_count_pin_out == $past(cmp_res)) // see R6
        else $error("comparator not driven onto pin");

    bus_answer_a: assert property (req_any && wait_q |=> !av_waitrequest ##1 av_waitrequest) // see R16
        else $error("bus answer not one cycle after request");

    // ==========================================================
    // Further checks
    edge_rise_a: assert property (ext_mode && !setup_q.edge_select && src_edge |-> src_raw) // see R4
        else $error("counted edge not rising");

    edge_fall_a: assert property (ext_mode && setup_q.edge_select && src_edge |-> !src_raw) // see R4
        else $error("counted edge not falling");

    cmp_internal_a: assert property (ext_mode && !cmpctl_q.comparator_clock_select |-> src_raw == cmp_res) // see R5
        else $error("comparator not routed internally");

    pin_source_a: assert property (pin_mode |-> src_raw == ext_count_pin_in) // see R3
        else $error("pin mode not counting the pin");

    ps_idle_a: assert property (!ps_clr && !ps_in |=> $stable(ps_q)) // see R7
        else $error("prescaler moved with no input");

    ps_step_a: assert property (!ps_clr && ps_in |=> ps_q == $past(ps_q) + 8'h01) // see R9
        else $error("prescaler missed a step");

    timer_idle_a: assert property (!ext_mode && psa_timer && !sync_rise && !wr_timer |=> $stable(timer_q)) // see R9
        else $error("prescaled timer moved without output");

    wdt_quiet_a: assert property (psa_timer |=> !wdt_post_tick) // see R7
        else $error("watchdog tick while timer owns prescaler");

    pin_dir_a: assert property (!ext_mode |=> ext_count_pin_oe_n == $past(pin_direction_q[`TCSP_PIN_BIT])) // see R15
        else $error("pin direction not followed");

    gpio_out_a: assert property (!loop_mode |=> ext_count_pin_out == $past(gpio_level)) // see R6
        else $error("pin level not from port latch");

    inhibit_load_a: assert property (wr_timer |=> inhibit_q == `TCSP_INHIBIT_CYC) // see R2
        else $error("inhibit not loaded on timer write");

    read_timer_a: assert property (av_req.read && wait_q && hit(av_req.address, `TCSP_IDX_TIMER)
        |=> av_readdata[7:0] == $past(timer_q)) // see R16
        else $error("timer read returned wrong value");

    read_upper_a: assert property (av_readdata[31:8] == 24'h00_0000) // see R16
        else $error("upper read bits not zero");

    q2_sample_a: assert property (phase_q == tcsp_pkg::PH_Q2 |=> samp2_q == $past(pre_out)) // see R10
        else $error("prescaler output not sampled at phase two");

endmodule : tcsp_timer

//--- tcsp_consts.svh
// Purpose: Offsets, reset values and timing counts of the shared-prescaler timer.
// Assumes: 32-bit register bus, one register per aligned word.
// Notes:   Byte address of a register is four times its index.
// ==========================================================
// How it works
// R1 - Internal source, no prescaler: timer counts once per instruction cycle.
// R2 - After any timer write, increments are held off for two instruction cycles.
// R3 - Source, clock-select and output-disable all set: count edges on external pin.
// R4 - Edge select clear counts rising edges, set counts falling edges.
// R5 - Source set, clock-select clear: comparator output counted internally.
// R6 - Source and clock-select set, disable clear: comparator drives pin, pin loops back.
// R7 - Prescaler serves timer or watchdog, never both; assign bit picks which.
// R8 - Prescaler count is never readable or writable by software.
// R9 - Timer prescale ratios run in powers of two from 1:2 to 1:256.
// R10 - Prescaler output sampled on phases two and four; source needs 2 Tosc levels. Code samples it at phase two only; phase four copies that sample.
// R11 - With prescaler, source period at least 4 Tosc over the ratio.
// R12 - Timer increments a short sync delay after the active external edge.
// R13 - Watchdog-to-timer move: clear watchdog first, then write setup with assign clear.
// R14 - Timer-to-watchdog move: clear watchdog, timer, interim setup, watchdog, then final.
// R15 - Source select set overrides the pin direction of the external count pin.
// R16 - Timer count is an 8-bit read/write register at index 01h.
// R17 - Timer write clears prescaler if timer owns it; watchdog clear if watchdog does.
// R18 - Every reset zeroes the prescaler count.
// R19 - Assign bit and three ratio bits set prescaler owner and ratio.
// R20 - Ratio n divides by 2 to n+1; timer wraps from ffh to 00h.
`ifndef TCSP_CONSTS_SVH
`define TCSP_CONSTS_SVH

// ==========================================================
// Register indices
`define TCSP_IDX_TIMER 6'h01
`define TCSP_IDX_CMPCTL 6'h07
`define TCSP_IDX_SETUP 6'h08
`define TCSP_IDX_PINDIR 6'h09
`define TCSP_IDX_WDTCLR 6'h0a

// ==========================================================
// Field positions
`define TCSP_PIN_BIT 2
`define TCSP_CMP_OUT_BIT 7

// ==========================================================
// Reset values
`define TCSP_RST_TIMER 8'h00
`define TCSP_RST_CMPCTL 8'hff
`define TCSP_RST_SETUP 8'hff
`define TCSP_RST_PINDIR 4'hf

// ==========================================================
// Timing counts, in instruction cycles
`define TCSP_INHIBIT_CYC 2'h2

`endif

//--- tcsp_pkg.sv
// Purpose: Types shared by the shared-prescaler timer.
// Assumes: Nothing beyond the constants header.
// Notes:   Struct layouts follow the register bit order, msb first.
package tcsp_pkg;

    // ==========================================================
    // Instruction-cycle phases
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } tcsp_phase_e;

    // ==========================================================
    // Setup register layout
    typedef struct packed {
        logic wake_dis;
        logic pullup_dis;
        logic count_source_sel;
        logic edge_select;
        logic prescaler_assign;
        logic [2:0] ratio_field;
    } tcsp_setup_s;

    // ==========================================================
    // Comparator control layout
    typedef struct packed {
        logic cmp_out;
        logic comparator_output_disable;
        logic polarity;
        logic comparator_clock_select;
        logic [3:0] analog_ctl;
    } tcsp_cmpctl_s;

    // ==========================================================
    // Avalon-MM request
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
    } tcsp_av_req_s;

endpackage : tcsp_pkg

//--- tcsp_src_model.sv
// Purpose: Far-side source: external count pin driver and comparator result.
// Assumes: Levels change just after a rising clk edge.
// Notes:   Each level stands 8 clk; idle level is low.
`timescale 1ns/100ps
module tcsp_src_model (
    // Clock
    input wire logic clk,
    // Source levels
    output logic pin_src,
    output logic cmp_src
);
    // ==========================================================
    // Drive
    initial begin
        pin_src = 1'b0;
        cmp_src = 1'b0;
    end

    // 8 clk per level, four times the 2 Tosc sampling need
    task automatic set_lvl(input logic to_cmp, input logic lvl);
        if (to_cmp) begin
            cmp_src <= lvl;
        end else begin
            pin_src <= lvl;
        end
        repeat (8) @(posedge clk);
    endtask : set_lvl

    task automatic pulses(input logic to_cmp, input int n);
        repeat (n) begin
            set_lvl(to_cmp, 1'b1);
            set_lvl(to_cmp, 1'b0);
        end
    endtask : pulses
endmodule : tcsp_src_model

//--- tcsp_timer_tb_top.sv
// Purpose: Self-checking bench of the shared-prescaler timer.
// Assumes: Avalon-MM with one wait cycle; 4 clk per instruction cycle.
// Notes:   Count deltas are taken over whole instruction cycles.
`timescale 1ns/100ps
module tcsp_timer_tb_top;
    logic clk;
    logic reset_n;
    tcsp_pkg::tcsp_av_req_s req;
    logic [31:0] rdata;
    logic wait_r;
    logic pin_out;
    logic oe_n;
    logic gpio_level;
    logic wdt_tick;
    logic post;
    logic pin_src;
    logic cmp_src;
    logic [7:0] q;
    logic [7:0] q1;
    int err_total;
    int checks_done;
    int c;
    wire pin_w = oe_n ? pin_src : pin_out;

    // ==========================================================
    // Instances
    tcsp_timer dut_u (.clk(clk), .reset_n(reset_n), .av_req(req), .av_readdata(rdata),
        .av_waitrequest(wait_r), .ext_count_pin_in(pin_w), .ext_count_pin_out(pin_out),
        .ext_count_pin_oe_n(oe_n), .gpio_level(gpio_level), .cmp_level(cmp_src),
        .wdt_tick(wdt_tick), .wdt_post_tick(post));
    tcsp_src_model src_u (.clk(clk), .pin_src(pin_src), .cmp_src(cmp_src));

    always #4 clk = ~clk;

    // ==========================================================
    // Tasks
    task automatic conclude();
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Request stands until waitrequest is seen low at a rising edge; one idle edge follows
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        req.read <= ~wr;
        req.write <= wr;
        req.address <= a;
        req.writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        r = rdata[7:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            err_total++;
            conclude();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        bus(1'b0, a, 8'h00, r);
    endtask : rd

    task automatic wdt_run(output int cnt);
        cnt = 0;
        repeat (16) begin
            wdt_tick <= 1'b1;
            for (int i = 0; i < 4; i++) begin
                @(negedge clk);
                cnt += (post === 1'b1);
                @(posedge clk);
                if (i == 0) begin
                    wdt_tick <= 1'b0;
                end
            end
        end
    endtask : wdt_run

    // ==========================================================
    // Sequence
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        req = '0;
        gpio_level = 1'b1;
        wdt_tick = 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h04, q); chk(q, 8'h00, "timer reset");
        rd(8'h1c, q); chk(q, 8'h7f, "cmpctl reset");
        rd(8'h20, q); chk(q, 8'h00, "setup read");
        wr(8'h3c, 8'h5a); rd(8'h3c, q); chk(q, 8'h00, "unmapped");
        chk(oe_n, 1'b1, "pin dir override");
        wr(8'h20, 8'h08); wr(8'h04, 8'ha5); rd(8'h04, q); chk(q, 8'ha5, "timer rw");
        repeat (8) @(posedge clk); rd(8'h04, q1); repeat (37) @(posedge clk);
        rd(8'h04, q); chk(q - q1, 8'd10, "instr count");
        wr(8'h04, 8'hfc); repeat (38) @(posedge clk);
        rd(8'h04, q); chk(q, 8'h04, "inhibit wrap");
        for (int n = 0; n < 8; n++) begin
            wr(8'h20, 8'(n)); wr(8'h04, 8'h00);
            repeat (8) @(posedge clk); rd(8'h04, q1); repeat (16 * (2 << n) - 3) @(posedge clk);
            rd(8'h04, q); chk(q - q1, 8'd4, "ratio");
        end
        wr(8'h28, 8'h00); wr(8'h04, 8'h00); wr(8'h20, 8'h0f); wr(8'h28, 8'h00);
        wr(8'h20, 8'h08); wdt_run(c); chk(c != 0, 1'b1, "wdt owns");
        wr(8'h28, 8'h00);
        wr(8'h20, 8'h00); wdt_run(c); chk(c, 8'd0, "timer owns");
        wr(8'h20, 8'h08); wr(8'h24, 8'h0b); repeat (2) @(posedge clk);
        chk(oe_n, 1'b0, "gpio oe"); chk(pin_out, 1'b1, "gpio out");
        gpio_level <= 1'b0; repeat (2) @(posedge clk); chk(pin_out, 1'b0, "gpio out");
        wr(8'h1c, 8'h50);
        for (int e = 0; e < 2; e++) begin
            wr(8'h20, 8'h28 | 8'(e << 4)); repeat (2) @(posedge clk);
            chk(oe_n, 1'b1, "pin dir override");
            wr(8'h04, 8'h00); repeat (16) @(posedge clk);
            fork
                src_u.set_lvl(1'b0, 1'b1);
                rd(8'h04, q);
            join
            chk(q, 8'h00, "sync delay");
            rd(8'h04, q); chk(q, 8'(1 - e), "edge rise");
            src_u.set_lvl(1'b0, 1'b0);
            rd(8'h04, q); chk(q, 8'h01, "edge fall");
            src_u.pulses(1'b0, 5);
            rd(8'h04, q); chk(q, 8'h06, "pin count");
        end
        for (int k = 0; k < 2; k++) begin
            wr(8'h1c, k ? 8'h00 : 8'h40); wr(8'h20, 8'h28); wr(8'h04, 8'h00);
            repeat (16) @(posedge clk);
            src_u.pulses(1'b1, 3);
            rd(8'h04, q); chk(q, 8'h03, "cmp internal");
        end
        wr(8'h1c, 8'h30); wr(8'h04, 8'h00); repeat (16) @(posedge clk);
        chk(oe_n, 1'b0, "loop oe"); chk(pin_out, cmp_src, "loop out");
        src_u.pulses(1'b1, 3);
        rd(8'h04, q); chk(q, 8'h03, "loop count");
        conclude();
    end
endmodule : tcsp_timer_tb_top
